// ===== arr_pkg.sv
// Constants, layout and prescaler decoding shared by the result readout block
`default_nettype none

package arr_pkg;

  // ----------------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ARR_RESULT_LOW_ADDR  = 8'h78;
  localparam logic [7:0] ARR_RESULT_HIGH_ADDR = 8'h79;
  localparam logic [7:0] ARR_RESULT_RESET     = 8'h00;
  localparam logic [7:0] ARR_UNMAPPED_DATA    = 8'h00;

  // ----------------------------------------------------------------------
  // Result layout
  // ----------------------------------------------------------------------
  localparam int         ARR_RESULT_W  = 10;
  localparam logic [5:0] ARR_PAD_ZERO  = 6'h00;

  // Channel codes that select single-ended inputs or internal references, not a differential pair
  localparam logic [1:0] ARR_SINGLE_GROUP = 2'h0;
  localparam logic [4:0] ARR_MUX_REF_LOW  = 5'h1E;

  // ----------------------------------------------------------------------
  // Prescaler division factors by code
  // ----------------------------------------------------------------------
  localparam logic [7:0] ARR_DIV_CODE0 = 8'h02;
  localparam logic [7:0] ARR_DIV_CODE1 = 8'h02;
  localparam logic [7:0] ARR_DIV_CODE2 = 8'h02;
  localparam logic [7:0] ARR_DIV_CODE3 = 8'h02;
  localparam logic [7:0] ARR_DIV_CODE4 = 8'h10;
  localparam logic [7:0] ARR_DIV_CODE5 = 8'h20;
  localparam logic [7:0] ARR_DIV_CODE6 = 8'h40;
  localparam logic [7:0] ARR_DIV_CODE7 = 8'h80;
  localparam int         ARR_DIV_MAX_W = 8;

  // Division factor for a prescaler code
  function automatic logic [7:0] arr_div_of(input logic [2:0] sel);
    case (sel)
      3'h0:    return ARR_DIV_CODE0;
      3'h1:    return ARR_DIV_CODE1;
      3'h2:    return ARR_DIV_CODE2;
      3'h3:    return ARR_DIV_CODE3;
      3'h4:    return ARR_DIV_CODE4;
      3'h5:    return ARR_DIV_CODE5;
      3'h6:    return ARR_DIV_CODE6;
      default: return ARR_DIV_CODE7;
    endcase
  endfunction : arr_div_of

  // True when the channel code picks a differential pair
  function automatic logic arr_is_diff(input logic [4:0] mux);
    return (mux[4:3] != ARR_SINGLE_GROUP) && (mux < ARR_MUX_REF_LOW);
  endfunction : arr_is_diff

  // Packs a raw code into {high, low}; offset code turns signed by MSB flip
  function automatic logic [15:0] arr_layout(input logic [9:0] v,
                                             input logic       left,
                                             input logic       diff);
    logic [9:0] r;
    r = diff ? {~v[9], v[8:0]} : v;
    return left ? {r, ARR_PAD_ZERO} : {ARR_PAD_ZERO, r};
  endfunction : arr_layout

endpackage : arr_pkg

`default_nettype wire

// ===== arr_psc_if.sv
// Link between the readout core and its converter clock prescaler
`timescale 1ns/1ps
`default_nettype none

interface arr_psc_if;
  logic [2:0] select;  // Prescaler code
  logic       tick;    // One-cycle converter clock enable

  modport ctrl (output select, input  tick);
  modport div  (input  select, output tick);
endinterface : arr_psc_if

`default_nettype wire

// ===== arr_prescaler.sv
// Converter clock prescaler: one-cycle enable every division-factor cycles
`timescale 1ns/1ps
`default_nettype none

module arr_prescaler #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Prescaler link
  arr_psc_if.div   psc
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  generate
    if (CNT_W < arr_pkg::ARR_DIV_MAX_W) begin : g_bad_width
      $error("prescaler counter too narrow for largest division");
    end
  endgenerate

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             tick;
    logic [2:0]       last_sel;
  } arr_psc_state_t;

  localparam arr_psc_state_t PSC_RESET = '{count: '0, tick: 1'b0, last_sel: 3'h0};

  arr_psc_state_t   st;
  arr_psc_state_t   next_st;
  logic [CNT_W-1:0] last_count;

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  // Restart on a code change so the first period is whole
  always_comb begin
    last_count       = CNT_W'(arr_pkg::arr_div_of(psc.select) - 8'h01);
    next_st          = st;
    next_st.last_sel = psc.select;
    next_st.tick     = (psc.select == st.last_sel) && (st.count == last_count);  // R10
    if ((psc.select != st.last_sel) || (st.count == last_count)) begin
      next_st.count = '0;
    end else begin
      next_st.count = st.count + 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= PSC_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign psc.tick = st.tick;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [7:0] chk_gap;
  logic       chk_valid;
  logic [2:0] chk_sel;

  // Independent count of cycles between enables under a steady code
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      chk_gap   <= 8'h00;
      chk_valid <= 1'b0;
      chk_sel   <= 3'h0;
    end else begin
      chk_sel <= psc.select;
      if (psc.select != chk_sel) begin
        chk_gap   <= 8'h00;
        chk_valid <= 1'b0;
      end else if (psc.tick) begin
        chk_gap   <= 8'h00;
        chk_valid <= 1'b1;
      end else begin
        chk_gap <= chk_gap + 8'h01;
      end
    end
  end

  property p_div_period;
    @(posedge i_clk) disable iff (i_reset)
      (psc.tick && chk_valid && (psc.select == chk_sel))
        |-> (chk_gap == arr_pkg::arr_div_of(psc.select) - 8'h01);
  endproperty
  a_div_period: assert property (p_div_period)  // R10
    else $error("converter enable spacing does not match the division factor");

  property p_div_16_quiet;
    @(posedge i_clk) disable iff (i_reset)
      (psc.tick && psc.select == 3'h4 && $stable(psc.select)) |=> !psc.tick [*8];
  endproperty
  a_div_16_quiet: assert property (p_div_16_quiet)  // R10
    else $error("enable repeated too soon at division 16");

  c_div_128: cover property (@(posedge i_clk) disable iff (i_reset)
    psc.tick && chk_valid && psc.select == 3'h7);

endmodule : arr_prescaler

`default_nettype wire

// ===== arr_result_readout.sv
// Converter result readout: byte registers, layout, read lock and prescaler
//
// How it works
// [R01] A finished conversion loads its value into the low and high result registers.
// [R02] The result is ten bits, spread across the two result bytes.
// [R03] Differential channel pairs present the result as two's complement.
// [R04] Reading the low byte freezes both registers until the high byte is read.
// [R05] Software reads the low byte first, then the high byte.
// [R06] Left adjusted eight-bit use may read only the high byte; no lock.
// [R07] Left adjust: bits 9..2 in high byte, bits 1..0 in low 7..6.
// [R08] Right adjust (default): bits 7..0 in low byte, bits 9..8 in high 1..0.
// [R09] Layout and signedness follow left adjust and the channel selection.
// [R10] Converter clock divides by 16, 32, 64 or 128 for codes 4 to 7.
// [R11] Results reset to zero, ignore writes; high byte read releases the lock.
`timescale 1ns/1ps
`default_nettype none

module arr_result_readout (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Processor data bus
  input  wire logic [7:0] i_addr,
  input  wire logic       i_rd,
  input  wire logic       i_wr,
  output logic      [7:0] o_rdata,
  output logic            o_rvalid,
  // Converter core
  input  wire logic       i_conv_done,
  input  wire logic [9:0] i_conv_value,
  output logic            o_conv_clk_en,
  // Configuration from the multiplexer and control registers
  input  wire logic       i_left_adjust_select,
  input  wire logic [4:0] i_channel_select_bits,
  input  wire logic [2:0] i_prescaler_select,
  // Status
  output logic            o_update_locked
);

  typedef struct packed {
    logic [7:0] res_low;
    logic [7:0] res_high;
    logic       locked;
    logic       left;
    logic [7:0] rdata;
    logic       rvalid;
  } arr_state_t;

  localparam arr_state_t ST_RESET = '{
    res_low:  arr_pkg::ARR_RESULT_RESET,
    res_high: arr_pkg::ARR_RESULT_RESET,
    locked:   1'b0,
    left:     1'b0,
    rdata:    arr_pkg::ARR_UNMAPPED_DATA,
    rvalid:   1'b0
  };

  arr_state_t  st;
  arr_state_t  next_st;
  logic        rd_low;
  logic        rd_high;
  logic        load;
  logic        diff;
  logic [15:0] packed_res;

  arr_psc_if psc ();

  // ----------------------------------------------------------------------
  // Converter clock prescaler
  // ----------------------------------------------------------------------
  assign psc.select = i_prescaler_select;

  arr_prescaler #(
    .CNT_W (arr_pkg::ARR_DIV_MAX_W)
  ) u_prescaler (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .psc     (psc.div)
  );

  // ----------------------------------------------------------------------
  // Read decode, lock and result loading
  // ----------------------------------------------------------------------
  always_comb begin
    rd_low     = i_rd && (i_addr == arr_pkg::ARR_RESULT_LOW_ADDR);
    rd_high    = i_rd && (i_addr == arr_pkg::ARR_RESULT_HIGH_ADDR);
    diff       = arr_pkg::arr_is_diff(i_channel_select_bits);  // R09
    packed_res = arr_pkg::arr_layout(i_conv_value, i_left_adjust_select, diff);  // R03
    // A low read in this cycle returns old data, so a load in the same cycle is dropped
    load       = i_conv_done && (!st.locked || rd_high) && !rd_low;  // R04
    next_st    = st;

    // Read answer one cycle later; unmapped reads answer zero
    next_st.rvalid = i_rd;
    if (rd_low) begin
      next_st.rdata = st.res_low;
    end else if (rd_high) begin
      next_st.rdata = st.res_high;
    end else begin
      next_st.rdata = arr_pkg::ARR_UNMAPPED_DATA;
    end

    // Low read engages the lock, high read releases it
    if (rd_low) begin
      next_st.locked = 1'b1;  // R04
    end else if (rd_high) begin
      next_st.locked = 1'b0;  // R11
    end

    // Writes to the result bytes have no effect
    if (load) begin
      next_st.res_high = packed_res[15:8];  // R01
      next_st.res_low  = packed_res[7:0];   // R07
      next_st.left     = i_left_adjust_select;  // R08
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= ST_RESET;  // R11
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata         = st.rdata;
  assign o_rvalid        = st.rvalid;
  assign o_update_locked = st.locked;
  assign o_conv_clk_en   = psc.tick;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_load;
    @(posedge i_clk) disable iff (i_reset)
      (i_conv_done && !st.locked && !rd_low) |=>
        ({st.res_high, st.res_low} == arr_pkg::arr_layout($past(i_conv_value),
          $past(i_left_adjust_select), arr_pkg::arr_is_diff($past(i_channel_select_bits))));
  endproperty
  a_load: assert property (p_load)  // R01
    else $error("finished conversion not loaded into result bytes");

  property p_unused_zero;
    @(posedge i_clk) disable iff (i_reset)
      st.left ? (st.res_low[5:0] == 6'h00) : (st.res_high[7:2] == 6'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero)  // R02
    else $error("bits outside the ten-bit result are not zero");

  property p_signed;
    @(posedge i_clk) disable iff (i_reset)
      (load && !i_left_adjust_select && arr_pkg::arr_is_diff(i_channel_select_bits))
        |=> (st.res_high[1] == !$past(i_conv_value[9]));
  endproperty
  a_signed: assert property (p_signed)  // R03
    else $error("differential result sign bit wrong");

  property p_lock_hold;
    @(posedge i_clk) disable iff (i_reset)
      (st.locked && !rd_high) |=> $stable({st.res_high, st.res_low});
  endproperty
  a_lock_hold: assert property (p_lock_hold)  // R04
    else $error("result changed while locked after a low byte read");

  property p_left_map;
    @(posedge i_clk) disable iff (i_reset)
      (load && i_left_adjust_select && !arr_pkg::arr_is_diff(i_channel_select_bits))
        |=> (st.res_high == $past(i_conv_value[9:2]))
            && (st.res_low[7:6] == $past(i_conv_value[1:0]));
  endproperty
  a_left_map: assert property (p_left_map)  // R07
    else $error("left adjusted layout wrong");

  property p_right_map;
    @(posedge i_clk) disable iff (i_reset)
      (load && !i_left_adjust_select && !arr_pkg::arr_is_diff(i_channel_select_bits))
        |=> (st.res_low == $past(i_conv_value[7:0]))
            && (st.res_high[1:0] == $past(i_conv_value[9:8]));
  endproperty
  a_right_map: assert property (p_right_map)  // R08
    else $error("right adjusted layout wrong");

  property p_left_signed;
    @(posedge i_clk) disable iff (i_reset)
      (load && i_left_adjust_select && arr_pkg::arr_is_diff(i_channel_select_bits))
        |=> (st.res_high[7] == !$past(i_conv_value[9]));
  endproperty
  a_left_signed: assert property (p_left_signed)  // R09
    else $error("left adjusted differential sign bit wrong");

  property p_release;
    @(posedge i_clk) disable iff (i_reset)
      (rd_high ##1 (i_conv_done && !rd_low)) |=> $past(load) && !st.locked;
  endproperty
  a_release: assert property (p_release)  // R11
    else $error("high byte read did not release the lock");

  property p_reset_zero;
    @(posedge i_clk) i_reset |=> (o_rdata == 8'h00) && (st.res_low == 8'h00)
                                 && (st.res_high == 8'h00) && !o_update_locked;
  endproperty
  a_reset_zero: assert property (p_reset_zero)  // R11
    else $error("result registers not zero after reset");

  property p_write_ignored;
    @(posedge i_clk) disable iff (i_reset)
      (i_wr && !i_conv_done) |=> $stable({st.res_high, st.res_low});
  endproperty
  a_write_ignored: assert property (p_write_ignored)  // R11
    else $error("write changed a result register");

  property p_read_answer;
    @(posedge i_clk) disable iff (i_reset)
      rd_high |=> o_rvalid && (o_rdata == $past(st.res_high));
  endproperty
  a_read_answer: assert property (p_read_answer)  // R01
    else $error("high byte read answered wrong data");

  c_locked_pair: cover property (@(posedge i_clk) disable iff (i_reset)
    rd_low ##[1:20] (rd_high && i_conv_done));
  c_blocked_load: cover property (@(posedge i_clk) disable iff (i_reset)
    st.locked && i_conv_done && !rd_high);
  c_diff_left: cover property (@(posedge i_clk) disable iff (i_reset)
    load && i_left_adjust_select && diff);

endmodule : arr_result_readout

`default_nettype wire

// ===== arr_result_readout_bench.sv
// Self-checking bench for the converter result readout block
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
  $display("BAD %0t %s", $time, msg); end end

module arr_result_readout_bench;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] d;
    logic       lk;
  } arr_note_t;

  logic       i_clk;
  logic       i_reset;
  logic [7:0] i_addr;
  logic       i_rd;
  logic       i_wr;
  logic [7:0] o_rdata;
  logic       o_rvalid;
  logic       i_conv_done;
  logic [9:0] i_conv_value;
  logic       o_conv_clk_en;
  logic       i_left_adjust_select;
  logic [4:0] i_channel_select_bits;
  logic [2:0] i_prescaler_select;
  logic       o_update_locked;
  int         n_fail;
  int         tests_run;
  arr_note_t  notes[$];
  logic [7:0] rl;
  logic [7:0] rh;
  logic       lock;
  logic [7:0] addr_tbl[4] = '{8'h78, 8'h79, 8'h7A, 8'h00};
  int         div_tbl[8];

  // ----------------------------------------------------------------------
  // Design under test
  // ----------------------------------------------------------------------
  arr_result_readout i_arr_result_readout (
    .i_clk                 (i_clk),
    .i_reset               (i_reset),
    .i_addr                (i_addr),
    .i_rd                  (i_rd),
    .i_wr                  (i_wr),
    .o_rdata               (o_rdata),
    .o_rvalid              (o_rvalid),
    .i_conv_done           (i_conv_done),
    .i_conv_value          (i_conv_value),
    .o_conv_clk_en         (o_conv_clk_en),
    .i_left_adjust_select  (i_left_adjust_select),
    .i_channel_select_bits (i_channel_select_bits),
    .i_prescaler_select    (i_prescaler_select),
    .o_update_locked       (o_update_locked)
  );

  // Clock generator, 4 ns period
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ----------------------------------------------------------------------
  // Expected layout and bus steps
  // ----------------------------------------------------------------------
  // Register pair image {high, low} of a raw code
  function automatic logic [15:0] lay(input logic [9:0] v, input logic l,
                                      input logic [4:0] c);
    logic [9:0] r;
    r = v;
    if (c[4:3] != 2'h0 && c < 5'h1E) r[9] = ~r[9];
    lay = l ? {r, 6'h00} : {6'h00, r};
  endfunction : lay

  // One bus cycle: drive all strobes, update the model, note the answer
  task automatic step(input logic rd, input logic [7:0] a, input logic wr, input logic dn,
                      input logic [9:0] v, input logic l, input logic [4:0] c);
    arr_note_t n;
    logic      lk0;
    logic      lo;
    logic      hi;
    @(posedge i_clk);
    i_rd                  <= rd;
    i_addr                <= a;
    i_wr                  <= wr;
    i_conv_done           <= dn;
    i_conv_value          <= v;
    i_left_adjust_select  <= l;
    i_channel_select_bits <= c;
    lk0  = lock;
    lo   = rd && (a == arr_pkg::ARR_RESULT_LOW_ADDR);
    hi   = rd && (a == arr_pkg::ARR_RESULT_HIGH_ADDR);
    n.d  = lo ? rl : (hi ? rh : arr_pkg::ARR_UNMAPPED_DATA);
    if (lo) lock = 1'b1;
    if (hi) lock = 1'b0;
    if (dn && !lo && (!lk0 || hi)) {rh, rl} = lay(v, l, c);
    n.lk = lock;
    if (rd) notes.push_back(n);
  endtask : step

  // Measures the enable spacing for one prescaler code
  task automatic psc(input logic [2:0] code);
    int k;
    @(posedge i_clk);
    i_prescaler_select <= code;
    for (int j = 0; j < 2; j++) begin
      k = 0;
      do begin
        @(negedge i_clk);
        k++;
      end while (o_conv_clk_en !== 1'b1 && k < 400);
    end
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (o_conv_clk_en !== 1'b1 && k < 400);
    `CHK(k, div_tbl[code], "prescaler spacing")
  endtask : psc

  // ----------------------------------------------------------------------
  // Answer monitor: oldest note against each read answer
  // ----------------------------------------------------------------------
  always @(negedge i_clk) begin
    if (o_rvalid === 1'b1) begin
      if (notes.size() == 0) begin
        `CHK(1'b1, 1'b0, "answer without read")
      end else begin
        `CHK(o_rdata, notes[0].d, "read data")
        `CHK(o_update_locked, notes[0].lk, "lock state")
        void'(notes.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------------
  // Closing task and watchdog
  // ----------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Cuts a hang short well past the expected run length
  initial begin
    #(4 * 20000);
    n_fail++;
    final_report();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    i_reset = 1'b1;
    i_addr = 8'h00;
    i_rd = 1'b0;
    i_wr = 1'b0;
    i_conv_done = 1'b0;
    i_conv_value = 10'h000;
    i_left_adjust_select = 1'b0;
    i_channel_select_bits = 5'h00;
    i_prescaler_select = 3'h4;
    n_fail = 0;
    tests_run = 0;
    rl = arr_pkg::ARR_RESULT_RESET;
    rh = arr_pkg::ARR_RESULT_RESET;
    lock = 1'b0;
    div_tbl = '{2, 2, 2, 2, 16, 32, 64, 128};
    void'($urandom(32'h6F26C61C));
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    // Reset values, writes ignored, unmapped read
    step(1'b0, 8'h78, 1'b1, 1'b0, 10'h000, 1'b0, 5'h00);
    step(1'b1, 8'h78, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    step(1'b1, 8'h79, 1'b1, 1'b0, 10'h000, 1'b0, 5'h00);
    step(1'b1, 8'h7A, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    // Lock holds a result across a low read; drops done pulses
    step(1'b0, 8'h00, 1'b0, 1'b1, 10'h2A5, 1'b0, 5'h00);
    step(1'b1, 8'h78, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    step(1'b0, 8'h00, 1'b0, 1'b1, 10'h3FF, 1'b1, 5'h08);
    step(1'b1, 8'h79, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    step(1'b1, 8'h78, 1'b0, 1'b1, 10'h155, 1'b0, 5'h00);
    step(1'b1, 8'h79, 1'b0, 1'b1, 10'h0F3, 1'b1, 5'h10);
    step(1'b1, 8'h78, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    step(1'b1, 8'h79, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    // High-only reads leave the path open for the next load
    step(1'b1, 8'h79, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    step(1'b0, 8'h00, 1'b0, 1'b1, 10'h301, 1'b1, 5'h1F);
    step(1'b1, 8'h79, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    // Random traffic of loads, reads, writes and layouts
    for (int i = 0; i < 400; i++) begin
      step(1'($urandom), addr_tbl[$urandom_range(3)], 1'($urandom), 1'($urandom),
           10'($urandom), 1'($urandom), 5'($urandom));
    end
    repeat (3) step(1'b0, 8'h00, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    `CHK(notes.size(), 0, "missing answers")
    // Mid-run reset clears both results and the lock
    i_reset <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    rl   = arr_pkg::ARR_RESULT_RESET;
    rh   = arr_pkg::ARR_RESULT_RESET;
    lock = 1'b0;
    step(1'b1, 8'h78, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    step(1'b1, 8'h79, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    repeat (2) step(1'b0, 8'h00, 1'b0, 1'b0, 10'h000, 1'b0, 5'h00);
    `CHK(notes.size(), 0, "missing answers after reset")
    // Every prescaler code
    for (int c = 0; c < 8; c++) psc(3'(c));
    final_report();
  end
endmodule : arr_result_readout_bench

`default_nettype wire
